// ---- hdl/eeprom_wr_host.v ----
`timescale 1ns/1ps
`include "eeprom_wr_defines.vh"
module eeprom_wr_host #(
	parameter ADDR_W        = 6,
	parameter [15:0] SK_HALF = `SK_HALF_CYCLES,
	parameter [31:0] POLL_MAX = `WRITE_MAX_CYC
) (
	// clock and reset
	input  wire              ref_clk,
	input  wire              reset,
	// command port
	input  wire              cmd_valid,
	output wire              cmd_ready,
	input  wire [2:0]        cmd_code,
	input  wire [ADDR_W-1:0] cmd_addr,
	input  wire [15:0]       cmd_data,
	output reg               done_ff,
	output reg               timeout_ff,
	output wire              busy,
	// memory pins
	output reg               chip_select_ff,
	output reg               serial_clock_ff,
	output reg               serial_in_ff,
	input  wire              serial_out
);
	localparam S_IDLE = 5'b00001;
	localparam S_SHIFT = 5'b00010;
	localparam S_GAP = 5'b00100;
	localparam S_POLL = 5'b01000;
	localparam S_DONE = 5'b10000;
	localparam FR_W = ADDR_W + 19;
	localparam [31:0] GAP_CYC = `CS_LOW_CYCLES;

	reg  [4:0]      state_ff;
	reg  [FR_W-1:0] shreg_ff;
	reg  [5:0]      bits_left_ff;
	reg             needs_poll_ff;
	reg  [15:0]     div_ff;
	reg  [31:0]     wait_ff;
	reg             sk_phase_ff;
	reg             dout_meta_ff;
	reg             dout_sync_ff;
	reg  [FR_W-1:0] nxt_frame;
	reg  [5:0]      nxt_bits;
	reg             nxt_poll;
	wire            tick;

	assign tick      = (div_ff == SK_HALF - 16'd1);
	assign cmd_ready = state_ff[0];
	assign busy      = ~state_ff[0];

	// frame built msb first; length exactly as the device counts it
	always @* begin
		nxt_frame = {FR_W{1'b0}};
		nxt_bits  = 6'd0;
		nxt_poll  = 1'b1;
		case (cmd_code)
		`CMD_WRITE: begin
			nxt_frame = {1'b1, `OPC_WRITE, cmd_addr, cmd_data};
			nxt_bits  = FR_W[5:0];
		end
		`CMD_ERASE: begin
			nxt_frame = {1'b1, `OPC_ERASE, cmd_addr, 16'h0000};
			nxt_bits  = FR_W[5:0] - 6'd16;
		end
		`CMD_FILL: begin
			nxt_frame = {1'b1, `OPC_EXT, `EXT_FILL,
				{(ADDR_W-2){1'b0}}, cmd_data};
			nxt_bits  = FR_W[5:0];
		end
		`CMD_ERASE_ALL: begin
			nxt_frame = {1'b1, `OPC_EXT, `EXT_ERASE_ALL,
				{(ADDR_W-2){1'b0}}, 16'h0000};
			nxt_bits  = FR_W[5:0] - 6'd16;
		end
		`CMD_ENABLE: begin
			nxt_frame = {1'b1, `OPC_EXT, `EXT_ENABLE,
				{(ADDR_W-2){1'b0}}, 16'h0000};
			nxt_bits  = FR_W[5:0] - 6'd16;
			nxt_poll  = 1'b0;
		end
		default: begin
			// disable, also the safe choice for unknown codes
			nxt_frame = {1'b1, `OPC_EXT, `EXT_DISABLE,
				{(ADDR_W-2){1'b0}}, 16'h0000};
			nxt_bits  = FR_W[5:0] - 6'd16;
			nxt_poll  = 1'b0;
		end
		endcase
	end

	// data out is asynchronous to ref_clk
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dout_meta_ff <= 1'b0;
			dout_sync_ff <= 1'b0;
		end else begin
			dout_meta_ff <= serial_out;
			dout_sync_ff <= dout_meta_ff;
		end
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff        <= S_IDLE;
			shreg_ff        <= {FR_W{1'b0}};
			bits_left_ff    <= 6'd0;
			needs_poll_ff   <= 1'b0;
			div_ff          <= 16'd0;
			wait_ff         <= 32'd0;
			sk_phase_ff     <= 1'b0;
			chip_select_ff  <= 1'b0;
			serial_clock_ff <= 1'b0;
			serial_in_ff    <= 1'b0;
			done_ff         <= 1'b0;
			timeout_ff      <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			div_ff  <= (state_ff[0] || tick) ? 16'd0 : div_ff + 16'd1;
			case (state_ff)
			S_IDLE: begin
				serial_clock_ff <= 1'b0;
				serial_in_ff    <= 1'b0;
				sk_phase_ff     <= 1'b0;
				if (cmd_valid) begin
					timeout_ff     <= 1'b0;
					shreg_ff       <= nxt_frame;
					bits_left_ff   <= nxt_bits;
					needs_poll_ff  <= nxt_poll;
					chip_select_ff <= 1'b1;
					// first bit must be the start bit
					serial_in_ff   <= 1'b1;
					state_ff       <= S_SHIFT;
				end
			end
			S_SHIFT: if (tick) begin
				if (!sk_phase_ff) begin
					serial_clock_ff <= 1'b1;
					sk_phase_ff     <= 1'b1;
				end else begin
					serial_clock_ff <= 1'b0;
					sk_phase_ff     <= 1'b0;
					shreg_ff        <= shreg_ff << 1;
					bits_left_ff    <= bits_left_ff - 6'd1;
					if (bits_left_ff == 6'd1) begin
						// select falls right after last clock: no extra edges
						chip_select_ff <= 1'b0;
						serial_in_ff   <= 1'b0;
						wait_ff        <= 32'd0;
						state_ff       <= S_GAP;
					end else begin
						serial_in_ff <= shreg_ff[FR_W-2];
					end
				end
			end
			S_GAP: begin
				wait_ff <= wait_ff + 32'd1;
				if (wait_ff >= GAP_CYC) begin
					wait_ff <= 32'd0;
					if (needs_poll_ff) begin
						chip_select_ff <= 1'b1;
						state_ff       <= S_POLL;
					end else begin
						state_ff <= S_DONE;
					end
				end
			end
			S_POLL: begin
				// no clocks while polling, data in held low
				serial_in_ff    <= 1'b0;
				serial_clock_ff <= 1'b0;
				wait_ff         <= wait_ff + 32'd1;
				// three cycles skipped for the two sync stages after select rises
				if (wait_ff > 32'd2 && dout_sync_ff) begin
					chip_select_ff <= 1'b0;
					state_ff       <= S_DONE;
				end else if (wait_ff >= POLL_MAX) begin
					// limitation: a disabled device never reports ready
					chip_select_ff <= 1'b0;
					timeout_ff     <= 1'b1;
					state_ff       <= S_DONE;
				end
			end
			S_DONE: begin
				done_ff  <= 1'b1;
				state_ff <= S_IDLE;
			end
			default: state_ff <= S_IDLE;
			endcase
		end
	end
endmodule

// ---- hdl/eeprom_wr_defines.vh ----
`ifndef EEPROM_WR_DEFINES_VH
`define EEPROM_WR_DEFINES_VH
// opcodes after the start bit
`define OPC_EXT        2'b00
`define OPC_WRITE      2'b01
`define OPC_ERASE      2'b11
// top two address bits select the opcode-00 commands
`define EXT_DISABLE    2'b00
`define EXT_FILL       2'b01
`define EXT_ERASE_ALL  2'b10
`define EXT_ENABLE     2'b11
// host command codes
`define CMD_WRITE      3'd0
`define CMD_ERASE      3'd1
`define CMD_FILL       3'd2
`define CMD_ERASE_ALL  3'd3
`define CMD_ENABLE     3'd4
`define CMD_DISABLE    3'd5
// serial clock half period in ref_clk cycles (4 ns each)
`define SK_HALF_CYCLES 16'd125
// chip select low time between frames: 0.4 us
`define CS_LOW_NS      400
`define CLK_PERIOD_NS  4
`define CS_LOW_CYCLES  ((`CS_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// write time ceiling: 8 ms
`define WRITE_MAX_NS   8000000
`define WRITE_MAX_CYC  (`WRITE_MAX_NS / `CLK_PERIOD_NS)
`endif

// ---- test/eeprom_wr_host_sva.sv ----
`timescale 1ns/1ps
module eeprom_wr_host_sva (
	input wire logic ref_clk, reset, cmd_valid, cmd_ready,
	input wire logic done_ff, timeout_ff, serial_out,
	input wire logic chip_select_ff, serial_clock_ff, serial_in_ff
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_idle; cmd_ready |-> !chip_select_ff; endproperty
	a_idle: assert property (p_idle) else $error("select in idle");
	property p_start;
		cmd_valid && cmd_ready |=> chip_select_ff && serial_in_ff;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_clk; serial_clock_ff |-> chip_select_ff; endproperty
	a_clk: assert property (p_clk) else $error("clock off frame");
	property p_steady;
		$rose(serial_clock_ff) |-> $stable(serial_in_ff);
	endproperty
	a_steady: assert property (p_steady) else $error("data moved");
	// a frame end must leave the device a real deselect gap
	property p_gap;
		$fell(chip_select_ff) ##1 !done_ff |-> !chip_select_ff [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("short gap");
	property p_quiet; chip_select_ff && serial_out |-> !serial_in_ff; endproperty
	a_quiet: assert property (p_quiet) else $error("data high poll");
	property p_noclk; serial_out |-> !serial_clock_ff; endproperty
	a_noclk: assert property (p_noclk) else $error("clock in poll");
	property p_done; done_ff |-> !chip_select_ff; endproperty
	a_done: assert property (p_done) else $error("select at done");
	c_done: cover property (done_ff);
	c_timeout: cover property ($rose(timeout_ff));
	c_ready: cover property (chip_select_ff && serial_out);
endmodule
bind eeprom_wr_host eeprom_wr_host_sva eeprom_wr_host_sva_inst (.*);

// ---- test/eeprom_mem_model.sv ----
`timescale 1ns/1ps
module eeprom_mem_model #(parameter PROG = 300) (
	input  wire ref_clk,
	input  wire low_supply,
	input  wire chip_select_ff,
	input  wire serial_clock_ff,
	input  wire serial_in_ff,
	output wire serial_out
);
	reg  [24:0] sr = 0;
	// last accepted write-type frame, for the bench to inspect
	reg  [24:0] last = 0;
	reg         en = 0, verify = 0, clk_q = 0, sel_q = 0;
	integer     n = 0, left = 0, writes = 0;
	wire [3:0]  h9 = sr[7:4];
	wire [3:0]  h25 = sr[23:20];
	wire        ok = en &&
		(n == 25 && (h25[3:2] == 2'b01 || h25 == 4'h1) ||
		n == 9 && (h9[3:2] == 2'b11 || h9 == 4'h2));
	// released line reads as pulled low
	assign serial_out = chip_select_ff && verify && left == 0;
	always @(posedge ref_clk) begin
		clk_q <= serial_clock_ff;
		sel_q <= chip_select_ff;
		if (left > 0)
			left <= left - 1;
		if (chip_select_ff && serial_clock_ff && !clk_q && left == 0 &&
			(n > 0 || serial_in_ff)) begin
			sr <= {sr[23:0], serial_in_ff};
			n <= n + 1;
		end
		if (sel_q && !chip_select_ff) begin
			verify <= ok;
			n <= 0;
			left <= ok ? PROG : left;
			writes <= writes + ok;
			if (ok)
				last <= sr;
			if (n == 9 && h9[3:2] == 2'b00 && h9[1] == h9[0])
				en <= h9[0];
		end
		if (low_supply) begin
			en <= 0;
			n <= 0;
		end
	end
endmodule

// ---- test/eeprom_wr_host_test.sv ----
`timescale 1ns/1ps
`include "eeprom_wr_defines.vh"
module eeprom_wr_host_test;
	reg         ref_clk = 0, reset = 1, cmd_valid = 0, low_supply = 0;
	reg  [2:0]  cmd_code = 0;
	reg  [5:0]  cmd_addr = 0;
	reg  [15:0] cmd_data = 16'ha5c3;
	wire        cmd_ready, done_ff, timeout_ff, busy, serial_out;
	wire        chip_select_ff, serial_clock_ff, serial_in_ff;
	integer     mismatches = 0, comparisons = 0, cyc = 0, c;
	always #2 ref_clk = ~ref_clk;
	eeprom_wr_host #(.SK_HALF(16'd4), .POLL_MAX(32'd2000)) eeprom_wr_host_inst (.*);
	eeprom_mem_model eeprom_mem_model_inst (.*);
	task chk(input [63:0] nm, input [31:0] e, g);
		begin
			comparisons = comparisons + 1;
			if (e !== g) begin
				mismatches = mismatches + 1;
				$display("mismatch %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task report_and_stop;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, mismatches);
			if (mismatches == 0 && comparisons > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task run(input [2:0] code, input to, input integer dw);
		integer w, k;
		begin
			w = eeprom_mem_model_inst.writes;
			@(negedge ref_clk);
			cmd_code = code;
			cmd_addr = {3'h5, code};
			cmd_valid = 1;
			chk("ready", 1, cmd_ready);
			@(negedge ref_clk);
			cmd_valid = 0;
			chk("busy", 1, busy);
			for (k = 0; k < 4000 && done_ff !== 1'b1; k = k + 1)
				@(negedge ref_clk);
			chk("done", 1, done_ff);
			chk("timeout", to, timeout_ff);
			chk("writes", dw, eeprom_mem_model_inst.writes - w);
			chk("select", 0, chip_select_ff);
		end
	endtask
	task t_locked;
		run(`CMD_WRITE, 1, 0);
	endtask
	task t_all_types;
		begin
			run(`CMD_ENABLE, 0, 0);
			chk("enabled", 1, eeprom_mem_model_inst.en);
			for (c = 0; c < 4; c = c + 1) begin
				run(c[2:0], 0, 1);
				if (c == 0)
					chk("frame", {7'h00, 1'b1, `OPC_WRITE, 3'h5, 3'h0,
						16'ha5c3}, eeprom_mem_model_inst.last);
			end
			run(`CMD_DISABLE, 0, 0);
			run(`CMD_FILL, 1, 0);
		end
	endtask
	task t_supply_drop;
		begin
			run(`CMD_ENABLE, 0, 0);
			@(negedge ref_clk);
			low_supply = 1;
			@(negedge ref_clk);
			low_supply = 0;
			run(`CMD_ERASE_ALL, 1, 0);
			run(`CMD_ENABLE, 0, 0);
			run(`CMD_ERASE, 0, 1);
		end
	endtask
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc > 60000) begin
			mismatches = mismatches + 1;
			report_and_stop;
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 0;
		t_locked;
		t_all_types;
		t_supply_drop;
		report_and_stop;
	end
endmodule
